// File: verilog/rail_supervisor_pkg.sv
package rail_supervisor_pkg;
  // one bit per supervised rail
  typedef struct packed {
    logic main;
    logic core;
    logic lin1;
    logic lin2;
  } rail_set_type;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_UP1   = 3'b001,
    ST_RUN   = 3'b010,
    ST_WARN  = 3'b011,
    ST_DOWN1 = 3'b100
  } seq_state_type;

  // register byte offsets
  localparam logic [7:0] MAIN_CFG_OFS = 8'h00;
  localparam logic [7:0] CORE_CFG_OFS = 8'h04;
  localparam logic [7:0] LIN_CFG_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS   = 8'h0C;
  localparam logic [7:0] MASK_OFS     = 8'h10;
  localparam logic [7:0] UNDERVOLTAGE_LOCKOUT_OFS     = 8'h14;

  // converter config field positions
  localparam int VSEL_LSB  = 0;
  localparam int CONV_EN   = 4;
  localparam int DISCH_EN  = 5;
  localparam int FORCED_PWM_BIT_BIT  = 7;
  // linear config field positions
  localparam int LIN1_LSB  = 0;
  localparam int LIN1_EN   = 3;
  localparam int LIN2_LSB  = 4;
  localparam int LIN2_EN   = 7;
  // status field positions
  localparam int PG_LSB    = 0;
  localparam int PG_PEND   = 4;
  localparam int COV_PEND  = 5;
  localparam int SHUT_BIT  = 6;
  localparam int SEQ_BIT   = 7;

  // voltage codes and reset values
  localparam logic [3:0] MAIN_1V8_CODE = 4'h1;
  localparam logic [3:0] MAIN_3V3_CODE = 4'h7;
  localparam logic [3:0] CORE_1V3_CODE = 4'h3;
  localparam logic [3:0] CORE_1V6_CODE = 4'h6;
  localparam logic [3:0] UNDERVOLTAGE_LOCKOUT_2V75_CODE = 4'h5;
  localparam logic [7:0] CONV_CFG_RST  = 8'h10;
  localparam logic [7:0] LIN_CFG_RST   = 8'h88;
  localparam logic [1:0] MASK_RST      = 2'h0;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int UNDERVOLTAGE_LOCKOUT_DELAY_NS = 10000;
  localparam int OT_DELAY_NS   = 10000;
  localparam int STEP_TIME_US  = 100;
  localparam logic [15:0] UNDERVOLTAGE_LOCKOUT_DELAY_CYC = 16'((UNDERVOLTAGE_LOCKOUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] OT_DELAY_CYC   = 16'((OT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int STEP_CYC = (STEP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
endpackage

// File: verilog/regulator_supervisor_sequencer.sv
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
// Summary of operation
// - output discharge off after reset, enabled per converter by its config register.
// - discharge load switched on when an enabled converter is shut down by fault.
// - per-rail power-good bad below -10%, good again only above -5%.
// - all four power-good states readable in the rail health status register.
// - maskable interrupt when any monitored rail drops below its threshold.
// - main and core monitors inactive while that converter is disabled.
// - power-on reset output follows main rail power-good.
// - main and core converters shut down on overtemperature.
// - overtemperature acts only with forced PWM or load-driven PWM operation.
// - both linear regulators enabled after reset.
// - host enables and sets voltage of linear regulators via config register.
// - both linear regulators monitored into status and interrupt.
// - second linear regulator monitor suppressed while it is disabled.
// - undervoltage threshold resets to the 2.75 V code.
// - host may rewrite undervoltage threshold; the new value drives comparison.
// - supply low: power-fail low at once, ordered disable after fixed delay.
// - overtemperature: same sequence after its own delay.
// - automatic restart once the fault has cleared.
// - strap 0: core up first, down last; strap 1: main first.
// - core default 1.3 V with strap low, 1.6 V with strap high.
// - main default 1.8 V with strap low, 3.3 V with strap high.
// - falling cover: interrupt, power-fail low, converters off, linears low power.
// - power-fail held low while power-on reset is low.
module regulator_supervisor_sequencer
  import rail_supervisor_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         wb_cyc_in,
  input  wire logic         wb_stb_in,
  input  wire logic         wb_we_in,
  input  wire logic [7:0]   wb_adr_in,
  input  wire logic [3:0]   wb_sel_in,
  input  wire logic [31:0]  wb_dat_in,
  output logic      [31:0]  wb_dat_out,
  output logic              wb_ack_out,
  input  wire rail_set_type rail_below_in,
  input  wire rail_set_type rail_above_in,
  input  wire logic         supply_low_in,
  input  wire logic         overtemp_in,
  input  wire logic         pwm_load_in,
  input  wire logic         battery_cover_in,
  input  wire logic         sequence_order_strap_in,
  input  wire logic         core_default_strap_in,
  input  wire logic         main_default_strap_in,
  output rail_set_type      rail_enable_out,
  output logic      [1:0]   discharge_out,
  output logic              lin_low_power_out,
  output logic      [3:0]   main_vsel_out,
  output logic      [3:0]   core_vsel_out,
  output logic      [2:0]   lin1_vsel_out,
  output logic      [2:0]   lin2_vsel_out,
  output logic      [3:0]   undervoltage_lockout_threshold_out,
  output logic              power_fail_n_out,
  output logic              power_on_reset_n_out,
  output logic              irq_out
);

  // elaboration check: step count must fit the 16-bit counter
  if (STEP_CYCLES < 1 || STEP_CYCLES > 65535) begin
    $error("STEP_CYCLES out of range");
  end

  logic [14:0]   sync1_ff;
  logic [14:0]   sync2_ff;
  rail_set_type  below_s;
  rail_set_type  above_s;
  logic          uv_s;
  logic          ot_s;
  logic          pwm_s;
  logic          cover_s;
  logic [2:0]    strap_s;
  logic [7:0]    main_cfg_ff;
  logic [7:0]    core_cfg_ff;
  logic [7:0]    lin_cfg_ff;
  logic [3:0]    undervoltage_lockout_ff;
  logic [1:0]    mask_ff;
  logic          seq_ff;
  logic [1:0]    strap_cnt_ff;
  logic          strap_done_ff;
  rail_set_type  pg_ff;
  rail_set_type  mon;
  rail_set_type  nxt_pg;
  logic          pg_pend_ff;
  logic          cov_pend_ff;
  logic          cover_d_ff;
  logic          pg_fall;
  logic          cover_fall;
  seq_state_type state_ff;
  logic [15:0]   cnt_ff;
  logic          first_on_ff;
  logic          second_on_ff;
  logic          shut_ff;
  logic          ot_q;
  logic          fault;
  logic          main_on;
  logic          core_on;
  logic          req;
  logic          wr;
  logic [7:0]    rd;
  logic [7:0]    status;
  logic [7:0]    wdat;

  // two-flop synchronisers for all pins but the bus and reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync1_ff <= 15'h0008; // cover bit idles high, no false fall
      sync2_ff <= 15'h0008;
    end else begin
      sync1_ff <= {rail_below_in, rail_above_in, supply_low_in, overtemp_in, pwm_load_in,
                   battery_cover_in, sequence_order_strap_in, core_default_strap_in,
                   main_default_strap_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign below_s = sync2_ff[14:11];
  assign above_s = sync2_ff[10:7];
  assign uv_s    = sync2_ff[6];
  assign ot_s    = sync2_ff[5];
  assign pwm_s   = sync2_ff[4];
  assign cover_s = sync2_ff[3];
  assign strap_s = sync2_ff[2:0];

  // bus decode
  assign req  = wb_cyc_in & wb_stb_in;
  assign wr   = req & wb_we_in & wb_ack_out & wb_sel_in[0];
  assign wdat = wb_dat_in[7:0];

  // ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req & ~wb_ack_out;
      if (req & ~wb_ack_out) begin
        wb_dat_out <= {24'h00_0000, rd};
      end
    end
  end

  assign status = {seq_ff, shut_ff, cov_pend_ff, pg_pend_ff, pg_ff};

  // read mux, unmapped reads zero
  always_comb begin
    case (wb_adr_in)
      MAIN_CFG_OFS: rd = main_cfg_ff;
      CORE_CFG_OFS: rd = core_cfg_ff;
      LIN_CFG_OFS:  rd = lin_cfg_ff;
      STATUS_OFS:   rd = status;
      MASK_OFS:     rd = {6'h00, mask_ff};
      UNDERVOLTAGE_LOCKOUT_OFS:     rd = {4'h0, undervoltage_lockout_ff};
      default:      rd = 8'h00;
    endcase
  end

  // strap capture a few cycles after reset release
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      strap_cnt_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
      seq_ff        <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == STRAP_WAIT) begin
        strap_done_ff <= 1'b1;
        seq_ff        <= strap_s[2];
      end
    end
  end

  // converter config registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      main_cfg_ff <= CONV_CFG_RST;
      core_cfg_ff <= CONV_CFG_RST;
    end else if (!strap_done_ff && strap_cnt_ff == STRAP_WAIT) begin
      main_cfg_ff[VSEL_LSB +: 4] <= strap_s[0] ? MAIN_3V3_CODE : MAIN_1V8_CODE;
      core_cfg_ff[VSEL_LSB +: 4] <= strap_s[1] ? CORE_1V6_CODE : CORE_1V3_CODE;
    end else if (wr) begin
      if (wb_adr_in == MAIN_CFG_OFS) begin
        main_cfg_ff <= wdat;
      end
      if (wb_adr_in == CORE_CFG_OFS) begin
        core_cfg_ff <= wdat;
      end
    end
  end

  // linear, threshold and mask registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lin_cfg_ff <= LIN_CFG_RST;
      undervoltage_lockout_ff    <= UNDERVOLTAGE_LOCKOUT_2V75_CODE;
      mask_ff    <= MASK_RST;
    end else if (wr) begin
      if (wb_adr_in == LIN_CFG_OFS) begin
        lin_cfg_ff <= wdat;
      end
      if (wb_adr_in == UNDERVOLTAGE_LOCKOUT_OFS) begin
        undervoltage_lockout_ff <= wdat[3:0];
      end
      if (wb_adr_in == MASK_OFS) begin
        mask_ff <= wdat[1:0];
      end
    end
  end

  // which monitors are live
  assign main_on  = rail_enable_out.main;
  assign core_on  = rail_enable_out.core;
  assign mon.main = main_on;
  assign mon.core = core_on;
  assign mon.lin1 = 1'b1;
  assign mon.lin2 = rail_enable_out.lin2;

  // hysteresis latch per rail; inactive monitor reads not good
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!mon[i]) begin
        nxt_pg[i] = 1'b0;
      end else if (below_s[i]) begin
        nxt_pg[i] = 1'b0;
      end else if (above_s[i]) begin
        nxt_pg[i] = 1'b1;
      end else begin
        nxt_pg[i] = pg_ff[i];
      end
    end
  end

  assign pg_fall    = |(pg_ff & mon & ~nxt_pg);
  assign cover_fall = cover_d_ff & ~cover_s;

  // power-good state and pending flags, set beats clear
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pg_ff       <= 4'h0;
      pg_pend_ff  <= 1'b0;
      cov_pend_ff <= 1'b0;
      cover_d_ff  <= 1'b1;
    end else begin
      pg_ff      <= nxt_pg;
      cover_d_ff <= cover_s;
      pg_pend_ff <= pg_fall | (pg_pend_ff & ~(wr && wb_adr_in == STATUS_OFS && wdat[PG_PEND]));
      cov_pend_ff <= cover_fall | (cov_pend_ff & ~(wr && wb_adr_in == STATUS_OFS && wdat[COV_PEND]));
    end
  end

  // interrupt, mask bit high blocks its source
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (pg_pend_ff & ~mask_ff[0]) | (cov_pend_ff & ~mask_ff[1]);
    end
  end

  assign ot_q  = ot_s & (main_cfg_ff[FORCED_PWM_BIT_BIT] | pwm_s);
  assign fault = uv_s | ot_q;

  // shutdown and restart sequencer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff     <= ST_OFF;
      cnt_ff       <= 16'h0000;
      first_on_ff  <= 1'b0;
      second_on_ff <= 1'b0;
      shut_ff      <= 1'b0;
    end else begin
      case (state_ff)
        ST_OFF: begin
          if (strap_done_ff && !fault && cover_s) begin
            first_on_ff <= 1'b1;
            shut_ff     <= 1'b0;
            cnt_ff      <= 16'(STEP_CYCLES);
            state_ff    <= ST_UP1;
          end
        end
        ST_UP1, ST_RUN: begin
          if (!cover_s) begin
            first_on_ff  <= 1'b0;
            second_on_ff <= 1'b0;
            shut_ff      <= 1'b1;
            state_ff     <= ST_OFF;
          end else if (fault) begin
            cnt_ff   <= uv_s ? UNDERVOLTAGE_LOCKOUT_DELAY_CYC : OT_DELAY_CYC;
            state_ff <= ST_WARN;
          end else if (state_ff == ST_UP1) begin
            if (cnt_ff <= 16'h0001) begin
              second_on_ff <= 1'b1;
              state_ff     <= ST_RUN;
            end else begin
              cnt_ff <= cnt_ff - 16'h0001;
            end
          end
        end
        ST_WARN: begin
          if (cnt_ff <= 16'h0001) begin
            second_on_ff <= 1'b0;
            shut_ff      <= 1'b1;
            cnt_ff       <= 16'(STEP_CYCLES);
            state_ff     <= ST_DOWN1;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        ST_DOWN1: begin
          if (cnt_ff <= 16'h0001) begin
            first_on_ff <= 1'b0;
            state_ff    <= ST_OFF;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        default: begin
          state_ff <= ST_OFF;
        end
      endcase
    end
  end

  // rail enables: strap 0 puts core first, strap 1 main first
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rail_enable_out   <= 4'h0;
      lin_low_power_out <= 1'b0;
    end else begin
      rail_enable_out.main <= main_cfg_ff[CONV_EN] & cover_s &
                              (seq_ff ? first_on_ff : second_on_ff);
      rail_enable_out.core <= core_cfg_ff[CONV_EN] & cover_s &
                              (seq_ff ? second_on_ff : first_on_ff);
      rail_enable_out.lin1 <= lin_cfg_ff[LIN1_EN] & second_on_ff;
      rail_enable_out.lin2 <= lin_cfg_ff[LIN2_EN] & second_on_ff;
      lin_low_power_out    <= ~cover_s;
    end
  end

  // discharge loads after a fault-driven disable
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      discharge_out <= 2'h0;
    end else begin
      discharge_out[0] <= main_cfg_ff[DISCH_EN] & shut_ff & ~rail_enable_out.main;
      discharge_out[1] <= core_cfg_ff[DISCH_EN] & shut_ff & ~rail_enable_out.core;
    end
  end

  // voltage selections and threshold to the analog side
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      main_vsel_out      <= MAIN_1V8_CODE;
      core_vsel_out      <= CORE_1V3_CODE;
      lin1_vsel_out      <= LIN_CFG_RST[LIN1_LSB +: 3];
      lin2_vsel_out      <= LIN_CFG_RST[LIN2_LSB +: 3];
      undervoltage_lockout_threshold_out <= UNDERVOLTAGE_LOCKOUT_2V75_CODE;
    end else begin
      main_vsel_out      <= main_cfg_ff[VSEL_LSB +: 4];
      core_vsel_out      <= core_cfg_ff[VSEL_LSB +: 4];
      lin1_vsel_out      <= lin_cfg_ff[LIN1_LSB +: 3];
      lin2_vsel_out      <= lin_cfg_ff[LIN2_LSB +: 3];
      undervoltage_lockout_threshold_out <= undervoltage_lockout_ff;
    end
  end

  // reset and power-fail pins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      power_on_reset_n_out <= 1'b0;
      power_fail_n_out     <= 1'b0;
    end else begin
      power_on_reset_n_out <= pg_ff.main;
      power_fail_n_out     <= ~fault & cover_s & (state_ff != ST_WARN) &
                              (state_ff != ST_DOWN1) & power_on_reset_n_out & pg_ff.main;
    end
  end

endmodule

// File: dv/rail_comparator_model.sv
`timescale 1ns/1ps
// comparator model of the four rails, ramp of two cycles after enable
module rail_comparator_model
  import rail_supervisor_pkg::*;
(
  input  wire logic         clk_in,
  input  wire rail_set_type rail_enable_in,
  input  wire rail_set_type droop_in,
  input  wire rail_set_type mid_in,
  output rail_set_type      rail_below_out,
  output rail_set_type      rail_above_out
);
  rail_set_type up_q1_ff;
  rail_set_type up_q2_ff;
  // rail output follows its enable after a short ramp
  always_ff @(posedge clk_in) begin
    up_q1_ff <= rail_enable_in;
    up_q2_ff <= up_q1_ff;
  end
  // droop pulls below -10%, mid parks the rail inside the hysteresis band
  assign rail_below_out = rail_set_type'(~up_q2_ff | droop_in);
  assign rail_above_out = rail_set_type'(up_q2_ff & ~droop_in & ~mid_in);
endmodule

// File: dv/regulator_supervisor_sequencer_properties.sv
`timescale 1ns/1ps
module regulator_supervisor_sequencer_properties
  import rail_supervisor_pkg::*;
(
  input wire logic         clk_in,
  input wire logic         sys_rst_in,
  input wire logic         wb_cyc_in,
  input wire logic         wb_stb_in,
  input wire logic         wb_ack_out,
  input wire logic         supply_low_in,
  input wire logic         battery_cover_in,
  input wire logic         sequence_order_strap_in,
  input wire rail_set_type rail_enable_out,
  input wire logic [1:0]   discharge_out,
  input wire logic         lin_low_power_out,
  input wire logic         power_fail_n_out,
  input wire logic         power_on_reset_n_out,
  input wire logic         irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // start of a bus request, and three quiet bus cycles
  sequence req_start_s;
    $rose(wb_cyc_in && wb_stb_in);
  endsequence
  sequence no_bus_s;
    !wb_cyc_in && !$past(wb_cyc_in) && !$past(wb_cyc_in, 2);
  endsequence
  ack_latency_a: assert property (req_start_s |=> wb_ack_out) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  irq_held_a: assert property (irq_out ##0 no_bus_s |=> irq_out) else $error("irq lost");
  por_main_a: assert property (!rail_enable_out.main [*4] |-> !power_on_reset_n_out)
    else $error("reset released with main off");
  fail_por_a: assert property (!power_on_reset_n_out [*2] |-> !power_fail_n_out)
    else $error("power fail high in reset");
  disch_off_a: assert property (|discharge_out |-> !(discharge_out[0] && rail_enable_out.main)
    && !(discharge_out[1] && rail_enable_out.core)) else $error("discharge on live rail");
  core_first_a: assert property ($rose(rail_enable_out.main) && !sequence_order_strap_in
    |-> rail_enable_out.core) else $error("main before core");
  main_first_a: assert property ($rose(rail_enable_out.core) && sequence_order_strap_in
    |-> rail_enable_out.main) else $error("core before main");
  core_last_a: assert property ($fell(rail_enable_out.core) && !sequence_order_strap_in
    |-> !rail_enable_out.main) else $error("core off before main");
  fail_undervoltage_lockout_a: assert property (supply_low_in [*5] |-> !power_fail_n_out)
    else $error("power fail high on low supply");
  cover_off_a: assert property (!battery_cover_in [*5] |-> lin_low_power_out
    && !rail_enable_out.main && !rail_enable_out.core) else $error("cover removal ignored");
endmodule

bind regulator_supervisor_sequencer regulator_supervisor_sequencer_properties u_props (
  .clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .supply_low_in, .battery_cover_in,
  .sequence_order_strap_in, .rail_enable_out, .discharge_out, .lin_low_power_out,
  .power_fail_n_out, .power_on_reset_n_out, .irq_out);

// File: dv/regulator_supervisor_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module regulator_supervisor_sequencer_bench
  import rail_supervisor_pkg::*;
;
  logic clk_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [7:0] wb_adr_in, rdat;
  logic [3:0] wb_sel_in, main_vsel_out, core_vsel_out, undervoltage_lockout_threshold_out;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic supply_low_in, overtemp_in, pwm_load_in, battery_cover_in, lin_low_power_out;
  logic sequence_order_strap_in, core_default_strap_in, main_default_strap_in;
  logic power_fail_n_out, power_on_reset_n_out, irq_out;
  logic [1:0] discharge_out;
  logic [2:0] lin1_vsel_out, lin2_vsel_out;
  rail_set_type rail_below_in, rail_above_in, rail_enable_out, droop, mid;
  int n_fail, total_checks;
  regulator_supervisor_sequencer #(.STEP_CYCLES(4)) u_dut (
    .clk_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
    .wb_dat_out, .wb_ack_out, .rail_below_in, .rail_above_in, .supply_low_in, .overtemp_in,
    .pwm_load_in, .battery_cover_in, .sequence_order_strap_in, .core_default_strap_in,
    .main_default_strap_in, .rail_enable_out, .discharge_out, .lin_low_power_out, .main_vsel_out,
    .core_vsel_out, .lin1_vsel_out, .lin2_vsel_out, .undervoltage_lockout_threshold_out, .power_fail_n_out,
    .power_on_reset_n_out, .irq_out);
  rail_comparator_model u_model (.clk_in, .rail_enable_in(rail_enable_out), .droop_in(droop),
    .mid_in(mid), .rail_below_out(rail_below_in), .rail_above_out(rail_above_in));
  // free running clock
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // one classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= {24'h00_0000, d};
    do begin
      @(posedge clk_in);
    end while (wb_ack_out !== 1'b1);
    rdat = wb_dat_out[7:0];
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(rdat, e)
  endtask
  task automatic wait_en(input rail_set_type e);
    int n;
    n = 0;
    while (rail_enable_out !== e && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    `CHK(rail_enable_out, e)
  endtask
  task automatic boot(input logic m, input logic c, input logic s);
    main_default_strap_in <= m;
    core_default_strap_in <= c;
    sequence_order_strap_in <= s;
    sys_rst_in <= 1'b1;
    cyc(20);
    sys_rst_in <= 1'b0;
    cyc(8);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    #(8 * 40000);
    n_fail++;
    summarize();
  end
  initial begin
    {wb_cyc_in, wb_stb_in, wb_we_in, supply_low_in, overtemp_in, pwm_load_in} = 6'h00;
    wb_adr_in = 8'h00;
    wb_dat_in = 32'h0000_0000;
    wb_sel_in = 4'hF;
    battery_cover_in = 1'b1;
    droop = 4'h0;
    mid = 4'h0;
    n_fail = 0;
    total_checks = 0;
    boot(1'b0, 1'b1, 1'b0);
    rd(MAIN_CFG_OFS, CONV_CFG_RST | {4'h0, MAIN_1V8_CODE});
    rd(CORE_CFG_OFS, CONV_CFG_RST | {4'h0, CORE_1V6_CODE});
    rd(LIN_CFG_OFS, LIN_CFG_RST);
    rd(UNDERVOLTAGE_LOCKOUT_OFS, {4'h0, UNDERVOLTAGE_LOCKOUT_2V75_CODE});
    rd(MASK_OFS, 8'h00);
    rd(8'h18, 8'h00);
    `CHK(discharge_out, 2'b00)
    wait_en(4'hF);
    cyc(6);
    rd(STATUS_OFS, 8'h0F);
    `CHK(power_on_reset_n_out, 1'b1)
    `CHK(irq_out, 1'b0)
    $display("test defaults done");
    wb(1'b1, LIN_CFG_OFS, 8'h35);
    cyc(6);
    `CHK(lin1_vsel_out, 3'h5)
    `CHK(lin2_vsel_out, 3'h3)
    rd(STATUS_OFS, 8'h1C);
    `CHK(irq_out, 1'b1)
    wb(1'b1, MASK_OFS, 8'h01);
    cyc(3);
    `CHK(irq_out, 1'b0)
    wb(1'b1, STATUS_OFS, 8'h10);
    wb(1'b1, MASK_OFS, 8'h00);
    wb(1'b1, LIN_CFG_OFS, LIN_CFG_RST);
    wait_en(4'hF);
    cyc(6);
    `CHK(irq_out, 1'b0)
    $display("test linear done");
    droop <= 4'h8;
    cyc(6);
    `CHK(power_on_reset_n_out, 1'b0)
    `CHK(power_fail_n_out, 1'b0)
    droop <= 4'h0;
    mid <= 4'h8;
    cyc(6);
    rd(STATUS_OFS, 8'h17);
    mid <= 4'h0;
    cyc(6);
    rd(STATUS_OFS, 8'h1F);
    wb(1'b1, STATUS_OFS, 8'h10);
    cyc(3);
    `CHK(irq_out, 1'b0)
    $display("test droop done");
    wb(1'b1, UNDERVOLTAGE_LOCKOUT_OFS, 8'h09);
    cyc(2);
    `CHK(undervoltage_lockout_threshold_out, 4'h9)
    wb(1'b1, MAIN_CFG_OFS, 8'h31);
    wb(1'b1, CORE_CFG_OFS, 8'h36);
    supply_low_in <= 1'b1;
    cyc(1000);
    `CHK(power_fail_n_out, 1'b0)
    `CHK(rail_enable_out, 4'hF)
    wait_en(4'h4);
    wait_en(4'h0);
    cyc(1); // discharge follows the disable by one cycle
    `CHK(discharge_out, 2'b11)
    supply_low_in <= 1'b0;
    wait_en(4'hF);
    `CHK(discharge_out, 2'b00)
    $display("test lockout done");
    overtemp_in <= 1'b1;
    cyc(1400);
    `CHK(rail_enable_out, 4'hF)
    `CHK(power_fail_n_out, 1'b1)
    pwm_load_in <= 1'b1;
    cyc(1000);
    `CHK(power_fail_n_out, 1'b0)
    `CHK(rail_enable_out, 4'hF)
    wait_en(4'h0);
    overtemp_in <= 1'b0;
    pwm_load_in <= 1'b0;
    wait_en(4'hF);
    $display("test overtemp done");
    wb(1'b1, STATUS_OFS, 8'h30);
    battery_cover_in <= 1'b0;
    cyc(6);
    `CHK(rail_enable_out, 4'h0)
    `CHK(irq_out, 1'b1)
    `CHK(lin_low_power_out, 1'b1)
    battery_cover_in <= 1'b1;
    wait_en(4'hF);
    `CHK(lin_low_power_out, 1'b0)
    $display("test cover done");
    boot(1'b1, 1'b0, 1'b1);
    main_default_strap_in <= 1'b0;
    cyc(6);
    rd(MAIN_CFG_OFS, CONV_CFG_RST | {4'h0, MAIN_3V3_CODE});
    rd(CORE_CFG_OFS, CONV_CFG_RST | {4'h0, CORE_1V3_CODE});
    `CHK(main_vsel_out, MAIN_3V3_CODE)
    `CHK(core_vsel_out, CORE_1V3_CODE)
    wait_en(4'hF);
    cyc(6);
    rd(STATUS_OFS, 8'h8F);
    $display("test straps done");
    summarize();
  end
endmodule
